// ==== rtl/bpoe_exec.sv ====
`timescale 1ns/100ps
`include "bpoe_defines.svh"

module bpoe_exec #(
  parameter int APB_AW = 8
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // system bus
  input wire logic [7:0] DATA_IN,
  input wire logic INT_REQ,
  output bpoe_pkg::bpoe_sysbus_t SYS_BUS,
  output logic INT_ACK
);
  import bpoe_pkg::*;

  // execution state
  bpoe_state_t state_q, state_d;
  bpoe_mode_t mode_q, mode_d;
  logic [2:0] tcnt_q, tcnt_d; // clock state within machine cycle
  // working registers
  logic [15:0] ptr_q, ptr_d; // pointer_pair
  logic [7:0] cnt_q, cnt_d; // count_reg
  logic [7:0] port_q, port_d; // port_reg
  logic [15:0] ip_q, ip_d; // instruction_pointer
  logic [7:0] flags_q, flags_d;
  logic [7:0] hold_q, hold_d; // byte fetched from memory
  logic [7:0] op1_q, op1_d; // first opcode byte
  logic [7:0] op2_q, op2_d; // second opcode byte
  logic [6:0] rfsh_q, rfsh_d; // refresh row counter
  // sticky status
  logic done_q, done_d;
  logic illegal_q, illegal_d;
  logic intr_q, intr_d;
  // outputs
  bpoe_sysbus_t bus_q, bus_d;
  logic int_ack_q, int_ack_d;
  logic [31:0] prdata_q, prdata_d;
  logic perr_q, perr_d;
  // pin synchronisers
  logic [7:0] din_s1_q, din_s2_q;
  logic int_s1_q, int_s2_q;

  // helpers
  logic t_last;
  logic apb_setup;
  logic apb_wr;
  logic idle;
  logic [7:0] cnt_dec;

  // length of each machine cycle in clock states
  function automatic logic [2:0] t_len(input bpoe_state_t s);
    logic [2:0] n;
    n = `BPOE_T_FETCH1;
    case (s)
      S_FETCH2: n = `BPOE_T_FETCH2;
      S_MEMRD: n = `BPOE_T_MEMRD;
      S_IOWR: n = `BPOE_T_IOWR;
      S_REPEAT: n = `BPOE_T_REPEAT;
      default: n = `BPOE_T_FETCH1;
    endcase
    return n;
  endfunction

  assign t_last = (tcnt_q == (t_len(state_q) - 3'h1));
  assign apb_setup = PSEL & ~PENABLE;
  // zero wait states, so every access phase completes
  assign apb_wr = PSEL & PENABLE & PWRITE;
  assign idle = (state_q == S_IDLE);
  assign cnt_dec = cnt_q - 8'h01; // wraps from zero to FF

  // outputs: data from flops, handshake combinational
  assign PRDATA = prdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & perr_q;
  assign SYS_BUS = bus_q;
  assign INT_ACK = int_ack_q;

  // apb read data and error, captured in the setup cycle
  always_comb begin
    prdata_d = prdata_q;
    perr_d = perr_q;
    if (apb_setup) begin
      prdata_d = 32'h00000000;
      perr_d = 1'b0;
      if (PADDR == APB_AW'(`BPOE_OFS_CTRL)) begin
        prdata_d = {16'h0000, op1_q, op2_q};
      end else if (PADDR == APB_AW'(`BPOE_OFS_STATUS)) begin
        prdata_d[`BPOE_ST_BUSY] = ~idle;
        prdata_d[`BPOE_ST_DONE] = done_q;
        prdata_d[`BPOE_ST_ILLEGAL] = illegal_q;
        prdata_d[`BPOE_ST_INTR] = intr_q;
      end else if (PADDR == APB_AW'(`BPOE_OFS_POINTER)) begin
        prdata_d = {16'h0000, ptr_q};
      end else if (PADDR == APB_AW'(`BPOE_OFS_COUNT)) begin
        prdata_d = {24'h000000, cnt_q};
      end else if (PADDR == APB_AW'(`BPOE_OFS_PORT)) begin
        prdata_d = {24'h000000, port_q};
      end else if (PADDR == APB_AW'(`BPOE_OFS_IPTR)) begin
        prdata_d = {16'h0000, ip_q};
      end else if (PADDR == APB_AW'(`BPOE_OFS_FLAGS)) begin
        prdata_d = {24'h000000, flags_q};
      end else begin
        // unmapped or unaligned address
        perr_d = 1'b1;
      end
    end
  end

  // next values of the execution engine
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    tcnt_d = tcnt_q + 3'h1;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    port_d = port_q;
    ip_d = ip_q;
    flags_d = flags_q;
    hold_d = hold_q;
    op1_d = op1_q;
    op2_d = op2_q;
    rfsh_d = rfsh_q;
    int_ack_d = 1'b0;
    // write one to clear; a set below overrides the clear
    done_d = done_q;
    illegal_d = illegal_q;
    intr_d = intr_q;
    if (apb_wr && (PADDR == APB_AW'(`BPOE_OFS_STATUS))) begin
      done_d = done_q & ~PWDATA[`BPOE_ST_DONE];
      illegal_d = illegal_q & ~PWDATA[`BPOE_ST_ILLEGAL];
      intr_d = intr_q & ~PWDATA[`BPOE_ST_INTR];
    end
    // software loads the working registers only while idle,
    // so a running transfer never sees a torn value
    if (apb_wr && idle) begin
      if (PADDR == APB_AW'(`BPOE_OFS_POINTER)) begin
        ptr_d = PWDATA[15:0];
      end else if (PADDR == APB_AW'(`BPOE_OFS_COUNT)) begin
        cnt_d = PWDATA[7:0];
      end else if (PADDR == APB_AW'(`BPOE_OFS_PORT)) begin
        port_d = PWDATA[7:0];
      end else if (PADDR == APB_AW'(`BPOE_OFS_IPTR)) begin
        ip_d = PWDATA[15:0];
      end else if (PADDR == APB_AW'(`BPOE_OFS_FLAGS)) begin
        flags_d = PWDATA[7:0];
      end
    end
    case (state_q)
      S_IDLE: begin
        tcnt_d = 3'h0;
        // start bit launches an instruction fetch at the instruction pointer
        if (apb_wr && (PADDR == APB_AW'(`BPOE_OFS_CTRL)) && PWDATA[`BPOE_CTRL_START]) begin
          state_d = S_FETCH1;
        end
      end
      S_FETCH1: begin
        if (t_last) begin
          op1_d = din_s2_q;
          tcnt_d = 3'h0;
          state_d = S_FETCH2;
        end
      end
      S_FETCH2: begin
        if (t_last) begin
          op2_d = din_s2_q;
          tcnt_d = 3'h0;
          state_d = S_MEMRD;
          ip_d = ip_q + `BPOE_IP_STEP;
          if (op1_q != `BPOE_PREFIX) begin
            state_d = S_IDLE;
            ip_d = ip_q;
            illegal_d = 1'b1;
          end else if (din_s2_q == `BPOE_OP_INC_REP) begin
            mode_d = M_INC_REP;
          end else if (din_s2_q == `BPOE_OP_DEC_ONE) begin
            mode_d = M_DEC_ONE;
          end else if (din_s2_q == `BPOE_OP_DEC_REP) begin
            mode_d = M_DEC_REP;
          end else begin
            // other opcodes are not handled here
            state_d = S_IDLE;
            ip_d = ip_q;
            illegal_d = 1'b1;
          end
        end
      end
      S_MEMRD: begin
        if (t_last) begin
          hold_d = din_s2_q;
          cnt_d = cnt_dec;
          flags_d[`BPOE_FLG_SUB] = 1'b1;
          // undefined flags keep their old value, carry untouched
          if (mode_q == M_DEC_ONE) begin
            flags_d[`BPOE_FLG_NIL] = (cnt_dec == 8'h00);
          end else begin
            flags_d[`BPOE_FLG_NIL] = 1'b1;
          end
          tcnt_d = 3'h0;
          state_d = S_IOWR;
        end
      end
      S_IOWR: begin
        if (t_last) begin
          tcnt_d = 3'h0;
          if (mode_q == M_INC_REP) begin
            ptr_d = ptr_q + 16'h0001;
          end else begin
            ptr_d = ptr_q - 16'h0001;
          end
          if ((mode_q != M_DEC_ONE) && (cnt_q != 8'h00)) begin
            ip_d = ip_q - `BPOE_IP_STEP;
            state_d = S_REPEAT;
          end else begin
            state_d = S_IDLE;
            done_d = 1'b1;
          end
        end
      end
      S_REPEAT: begin
        if (tcnt_q < `BPOE_T_RFSH) begin
          rfsh_d = rfsh_q + 7'h01;
        end
        if (t_last) begin
          tcnt_d = 3'h0;
          // pending interrupt is taken between bytes; the pointer
          // already points back at the instruction, so a restart resumes
          if (int_s2_q) begin
            state_d = S_IDLE;
            intr_d = 1'b1;
            int_ack_d = 1'b1;
          end else begin
            state_d = S_FETCH1;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
        tcnt_d = 3'h0;
      end
    endcase
  end

  // bus drive follows the next phase so it is valid for the whole cycle
  always_comb begin
    bus_d = '0;
    case (state_d)
      S_FETCH1: begin
        bus_d.addr = ip_d;
        bus_d.mem_rd = 1'b1;
      end
      S_FETCH2: begin
        bus_d.addr = ip_d + 16'h0001;
        bus_d.mem_rd = 1'b1;
      end
      S_MEMRD: begin
        bus_d.addr = ptr_d;
        bus_d.mem_rd = 1'b1;
      end
      S_IOWR: begin
        bus_d.addr = {cnt_d, port_d};
        bus_d.dout = hold_d;
        bus_d.dout_oe = 1'b1;
        bus_d.io_wr = 1'b1;
      end
      S_REPEAT: begin
        if (tcnt_d < `BPOE_T_RFSH) begin
          bus_d.addr = {9'h000, rfsh_d};
          bus_d.rfsh = 1'b1;
        end
      end
      default: begin
        bus_d = '0;
      end
    endcase
  end

  // all state registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_q <= S_IDLE;
      mode_q <= M_DEC_ONE;
      tcnt_q <= 3'h0;
      ptr_q <= `BPOE_RST_WORD;
      cnt_q <= `BPOE_RST_BYTE;
      port_q <= `BPOE_RST_BYTE;
      ip_q <= `BPOE_RST_WORD;
      flags_q <= `BPOE_RST_BYTE;
      hold_q <= `BPOE_RST_BYTE;
      op1_q <= `BPOE_RST_BYTE;
      op2_q <= `BPOE_RST_BYTE;
      rfsh_q <= 7'h00;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      intr_q <= 1'b0;
      bus_q <= '0;
      int_ack_q <= 1'b0;
      prdata_q <= 32'h00000000;
      perr_q <= 1'b0;
      din_s1_q <= `BPOE_RST_BYTE;
      din_s2_q <= `BPOE_RST_BYTE;
      int_s1_q <= 1'b0;
      int_s2_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      tcnt_q <= tcnt_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      port_q <= port_d;
      ip_q <= ip_d;
      flags_q <= flags_d;
      hold_q <= hold_d;
      op1_q <= op1_d;
      op2_q <= op2_d;
      rfsh_q <= rfsh_d;
      done_q <= done_d;
      illegal_q <= illegal_d;
      intr_q <= intr_d;
      bus_q <= bus_d;
      int_ack_q <= int_ack_d;
      prdata_q <= prdata_d;
      perr_q <= perr_d;
      // pins pass two flops before any use
      din_s1_q <= DATA_IN;
      din_s2_q <= din_s1_q;
      int_s1_q <= INT_REQ;
      int_s2_q <= int_s1_q;
    end
  end

  // checks
  property p_prefix;
    @(posedge REF_CLK) disable iff (RST)
    (state_q == S_FETCH2) ##1 (state_q == S_MEMRD) |-> op1_q == `BPOE_PREFIX;
  endproperty
  a_prefix: assert property (p_prefix) else $error("executed without ED prefix");

  property p_decode;
    @(posedge REF_CLK) disable iff (RST)
    $rose(state_q == S_MEMRD) |->
      ((op2_q == `BPOE_OP_INC_REP) == (mode_q == M_INC_REP)) && ((op2_q == `BPOE_OP_DEC_REP) == (mode_q == M_DEC_REP));
  endproperty
  a_decode: assert property (p_decode) else $error("second byte decoded to wrong form");

  property p_single;
    @(posedge REF_CLK) disable iff (RST)
    (state_q == S_IOWR) && t_last && (mode_q == M_DEC_ONE) |=>
      (state_q == S_IDLE) && (ptr_q == $past(ptr_q) - 16'h0001) && done_q;
  endproperty
  a_single: assert property (p_single) else $error("single form did not end with pointer minus one");

  property p_io_cycle;
    @(posedge REF_CLK) disable iff (RST)
    (state_q == S_IOWR) |->
      bus_q.io_wr && bus_q.dout_oe && (bus_q.addr == {cnt_q, port_q}) && (bus_q.dout == hold_q);
  endproperty
  a_io_cycle: assert property (p_io_cycle) else $error("output cycle address or data wrong");

  property p_count_dec;
    @(posedge REF_CLK) disable iff (RST)
    (state_q == S_MEMRD) && t_last |=> (cnt_q == $past(cnt_q) - 8'h01) && (state_q == S_IOWR);
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count not decremented before output");

  property p_inc_ptr;
    @(posedge REF_CLK) disable iff (RST)
    (state_q == S_IOWR) && t_last && (mode_q == M_INC_REP) |=> ptr_q == $past(ptr_q) + 16'h0001;
  endproperty
  a_inc_ptr: assert property (p_inc_ptr) else $error("incrementing form did not add one");

  property p_repeat;
    @(posedge REF_CLK) disable iff (RST)
    (state_q == S_IOWR) && t_last && (mode_q != M_DEC_ONE) && (cnt_q != 8'h00) |=>
      (ip_q == $past(ip_q) - `BPOE_IP_STEP) ##0 (state_q == S_REPEAT) [*5] ##1 (state_q != S_REPEAT);
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat pass wrong pointer or length");

  property p_final;
    @(posedge REF_CLK) disable iff (RST)
    (state_q == S_IOWR) && t_last && (cnt_q == 8'h00) |=> (state_q == S_IDLE) && done_q;
  endproperty
  a_final: assert property (p_final) else $error("repeat did not end at zero count");

  // an undecodable opcode drops to idle right after the second fetch
  property p_timing;
    @(posedge REF_CLK) disable iff (RST)
    $rose(state_q == S_FETCH1) |->
      (state_q == S_FETCH1) [*4] ##1 (state_q == S_FETCH2) [*5]
      ##1 (((state_q == S_MEMRD) [*3] ##1 (state_q == S_IOWR) [*4]) or (state_q == S_IDLE));
  endproperty
  a_timing: assert property (p_timing) else $error("machine cycle lengths wrong");

  property p_refresh;
    @(posedge REF_CLK) disable iff (RST)
    $rose(state_q == S_REPEAT) |-> bus_q.rfsh [*2] ##1 !bus_q.rfsh;
  endproperty
  a_refresh: assert property (p_refresh) else $error("two refresh cycles missing");

  property p_flags;
    @(posedge REF_CLK) disable iff (RST)
    (state_q == S_MEMRD) && t_last |=>
      flags_q[`BPOE_FLG_SUB] && (flags_q[`BPOE_FLG_CARRY] == $past(flags_q[`BPOE_FLG_CARRY]))
      && (flags_q[`BPOE_FLG_NIL] == ((mode_q != M_DEC_ONE) || (cnt_q == 8'h00)));
  endproperty
  a_flags: assert property (p_flags) else $error("condition flags wrong after decrement");

endmodule

// ==== rtl/bpoe_defines.svh ====
`ifndef BPOE_DEFINES_SVH
`define BPOE_DEFINES_SVH

// opcode bytes of the three block output forms
`define BPOE_PREFIX 8'hED
`define BPOE_OP_INC_REP 8'hB3
`define BPOE_OP_DEC_ONE 8'hAB
`define BPOE_OP_DEC_REP 8'hBB

// clock states per machine cycle, one state per REF_CLK period
`define BPOE_T_FETCH1 3'h4
`define BPOE_T_FETCH2 3'h5
`define BPOE_T_MEMRD 3'h3
`define BPOE_T_IOWR 3'h4
`define BPOE_T_REPEAT 3'h5
// refresh occupies the first two states of the repeat cycle
`define BPOE_T_RFSH 3'h2
// instruction length stepped back on a repeat
`define BPOE_IP_STEP 16'h0002

// apb byte offsets
`define BPOE_OFS_CTRL 8'h00
`define BPOE_OFS_STATUS 8'h04
`define BPOE_OFS_POINTER 8'h08
`define BPOE_OFS_COUNT 8'h0C
`define BPOE_OFS_PORT 8'h10
`define BPOE_OFS_IPTR 8'h14
`define BPOE_OFS_FLAGS 8'h18

// control and status bits
`define BPOE_CTRL_START 0
`define BPOE_ST_BUSY 0
`define BPOE_ST_DONE 1
`define BPOE_ST_ILLEGAL 2
`define BPOE_ST_INTR 3

// condition flag positions
`define BPOE_FLG_CARRY 0
`define BPOE_FLG_SUB 1
`define BPOE_FLG_NIL 6

// reset values
`define BPOE_RST_BYTE 8'h00
`define BPOE_RST_WORD 16'h0000

`endif

// ==== rtl/bpoe_pkg.sv ====
package bpoe_pkg;

  // one-hot execution phases
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_FETCH1 = 6'b000010,
    S_FETCH2 = 6'b000100,
    S_MEMRD = 6'b001000,
    S_IOWR = 6'b010000,
    S_REPEAT = 6'b100000
  } bpoe_state_t;

  // decoded instruction form
  typedef enum logic [2:0] {
    M_INC_REP = 3'b001,
    M_DEC_ONE = 3'b010,
    M_DEC_REP = 3'b100
  } bpoe_mode_t;

  // system bus drive toward memory and peripherals
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] dout;
    logic dout_oe;
    logic mem_rd;
    logic io_wr;
    logic rfsh;
  } bpoe_sysbus_t;

endpackage

// ==== sim/bpoe_sysmodel.sv ====
`timescale 1ns/100ps
// memory and output port on the far side of the system bus
module bpoe_sysmodel (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // system bus
  input wire bpoe_pkg::bpoe_sysbus_t bus,
  output logic [7:0] data_in
);
  import bpoe_pkg::*;
  logic [7:0] mem [0:65535]; // memory image
  logic [7:0] last_q; // last byte on the data pins
  logic wr_q; // output strobe, one clock late
  int cyc; // cycle stamp
  logic [7:0] out_data [$]; // bytes taken by the port
  logic [15:0] out_addr [$]; // address seen with each byte
  int out_time [$]; // stamp of each byte
  int bus_cycles; // clocks with read or output strobe
  int rfsh_cycles; // refresh clocks
  // unselected pins toggle, so a stale byte never reads as valid
  assign data_in = bus.mem_rd ? mem[bus.addr] : ~last_q;
  // port takes the byte once, on the first clock of each output cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 8'h00;
      wr_q <= 1'b0;
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      last_q <= data_in;
      wr_q <= bus.io_wr;
      if (bus.mem_rd || bus.io_wr) bus_cycles <= bus_cycles + 1;
      if (bus.rfsh) rfsh_cycles <= rfsh_cycles + 1;
      if (bus.io_wr && !wr_q && bus.dout_oe) begin
        out_data.push_back(bus.dout);
        out_addr.push_back(bus.addr);
        out_time.push_back(cyc);
      end
    end
  end
endmodule

// ==== sim/bpoe_exec_tb.sv ====
`timescale 1ns/100ps
`include "bpoe_defines.svh"
// self-checking bench: apb master, bus model, one task per scenario
module bpoe_exec_tb;
  import bpoe_pkg::*;
  // clock, reset and bench-driven inputs
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic int_req = 1'b0;
  // design and bus model outputs
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] data_in;
  bpoe_sysbus_t sys_bus;
  logic int_ack;
  // bookkeeping
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int acks = 0; // acknowledge pulses seen
  logic [31:0] rv; // last read word
  logic re; // last error response

  bpoe_exec #(.APB_AW(8)) uut (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DATA_IN(data_in), .INT_REQ(int_req), .SYS_BUS(sys_bus), .INT_ACK(int_ack));
  bpoe_sysmodel m (.clk(ref_clk), .rst(rst), .bus(sys_bus), .data_in(data_in));

  // 40 ns period
  initial forever #20 ref_clk = ~ref_clk;

  // hang guard; the longest run is a 256-byte repeat
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (int_ack === 1'b1) acks <= acks + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      $display("Error timeout expected under 20000 cycles seen 20000");
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(n, e, rv);
  endtask

  // opcode into memory, registers loaded, logs cleared; carry preset
  task automatic setup(input logic [7:0] o1, o2, input logic [15:0] ip, h, input logic [7:0] b, p);
    m.mem[ip] = o1;
    m.mem[ip + 16'h0001] = o2;
    m.out_data.delete();
    m.out_addr.delete();
    m.out_time.delete();
    m.bus_cycles = 0;
    m.rfsh_cycles = 0;
    acks = 0;
    apb(1'b1, `BPOE_OFS_IPTR, {16'h0000, ip});
    apb(1'b1, `BPOE_OFS_POINTER, {16'h0000, h});
    apb(1'b1, `BPOE_OFS_COUNT, {24'h000000, b});
    apb(1'b1, `BPOE_OFS_PORT, {24'h000000, p});
    apb(1'b1, `BPOE_OFS_FLAGS, 32'h00000001);
  endtask

  // start and poll until done, illegal or interrupted
  task automatic go();
    int n;
    n = 0;
    apb(1'b1, `BPOE_OFS_STATUS, 32'h0000000F);
    apb(1'b1, `BPOE_OFS_CTRL, 32'h00000001);
    do begin
      apb(1'b0, `BPOE_OFS_STATUS, 32'h00000000);
      n++;
    end while (rv[3:1] === 3'b000 && n < 3000);
    // a run that never ends is a mismatch, not a silent return
    if (n >= 3000) chk("poll limit", 32'h00000000, 32'h00000001);
  endtask

  // bytes, addresses and pass spacing against the memory image
  task automatic chk_seq(input logic [15:0] h0, input logic dec, input int n, input logic [7:0] b0, p);
    logic [15:0] h;
    chk("outputs", n, m.out_data.size());
    for (int i = 0; i < n; i++) begin
      h = dec ? h0 - 16'(i) : h0 + 16'(i);
      chk("byte", {24'h000000, m.mem[h]}, {24'h000000, m.out_data[i]});
      chk("addr", {16'h0000, b0 - 8'(i + 1), p}, {16'h0000, m.out_addr[i]});
      if (i > 0) chk("gap", 32'h15, m.out_time[i] - m.out_time[i - 1]);
    end
  endtask

  task automatic t_regs();
    rdc("count", `BPOE_OFS_COUNT, 32'h00000000);
    rdc("status", `BPOE_OFS_STATUS, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000);
    chk("unmapped", 32'h00000001, {31'h00000000, re});
    $display("test regs done");
  endtask

  task automatic t_single();
    m.mem[16'h1000] = 8'h59;
    m.mem[16'h0FFF] = 8'hA5;
    setup(`BPOE_PREFIX, `BPOE_OP_DEC_ONE, 16'h0100, 16'h1000, 8'h10, 8'h07);
    go();
    chk_seq(16'h1000, 1'b1, 1, 8'h10, 8'h07);
    chk("clocks", 32'h10, m.bus_cycles);
    chk("refresh", 32'h0, m.rfsh_cycles);
    rdc("pointer", `BPOE_OFS_POINTER, 32'h00000FFF);
    rdc("count", `BPOE_OFS_COUNT, 32'h0000000F);
    rdc("flags", `BPOE_OFS_FLAGS, 32'h00000003);
    rdc("iptr", `BPOE_OFS_IPTR, 32'h00000102);
    rdc("ctrl", `BPOE_OFS_CTRL, 32'h0000EDAB);
    rdc("port", `BPOE_OFS_PORT, 32'h00000007);
    setup(`BPOE_PREFIX, `BPOE_OP_DEC_ONE, 16'h0100, 16'h0FFF, 8'h01, 8'h07);
    go();
    chk_seq(16'h0FFF, 1'b1, 1, 8'h01, 8'h07);
    rdc("flags", `BPOE_OFS_FLAGS, 32'h00000043);
    $display("test single done");
  endtask

  task automatic t_rep(input logic dec, input logic [7:0] op, input logic [15:0] ip);
    for (int i = 0; i < 5; i++) m.mem[16'h0FFE + 16'(i)] = 8'h51 + 8'(i * 37);
    setup(`BPOE_PREFIX, op, ip, 16'h1000, 8'h03, 8'h07);
    go();
    chk_seq(16'h1000, dec, 3, 8'h03, 8'h07);
    chk("refresh", 32'h4, m.rfsh_cycles);
    chk("clocks", 32'h30, m.bus_cycles);
    rdc("pointer", `BPOE_OFS_POINTER, dec ? 32'h00000FFD : 32'h00001003);
    rdc("count", `BPOE_OFS_COUNT, 32'h00000000);
    rdc("iptr", `BPOE_OFS_IPTR, {16'h0000, ip + `BPOE_IP_STEP});
    rdc("flags", `BPOE_OFS_FLAGS, 32'h00000043);
    $display("test repeat done");
  endtask

  task automatic t_wrap();
    for (int i = 0; i < 256; i++) m.mem[16'h2000 + 16'(i)] = 8'(i) ^ 8'h5A;
    setup(`BPOE_PREFIX, `BPOE_OP_INC_REP, 16'h0400, 16'h2000, 8'h00, 8'h33);
    go();
    chk_seq(16'h2000, 1'b0, 256, 8'h00, 8'h33);
    rdc("pointer", `BPOE_OFS_POINTER, 32'h00002100);
    $display("test wrap done");
  endtask

  task automatic t_illegal();
    logic [7:0] bad [4] = '{8'h00, `BPOE_OP_INC_REP, `BPOE_PREFIX, 8'hA3};
    for (int k = 0; k < 2; k++) begin
      setup(bad[2 * k], bad[2 * k + 1], 16'h0500, 16'h1000, 8'h03, 8'h07);
      go();
      chk("illegal", 32'h1, {31'h00000000, rv[`BPOE_ST_ILLEGAL]});
      chk("outputs", 32'h0, m.out_data.size());
      rdc("iptr", `BPOE_OFS_IPTR, 32'h00000500);
    end
    $display("test illegal done");
  endtask

  task automatic t_intr();
    @(posedge ref_clk);
    int_req <= 1'b1;
    setup(`BPOE_PREFIX, `BPOE_OP_DEC_REP, 16'h0600, 16'h1000, 8'h03, 8'h07);
    go();
    chk("intr", 32'h1, {31'h00000000, rv[`BPOE_ST_INTR]});
    chk("ack", 32'h1, acks);
    chk("outputs", 32'h1, m.out_data.size());
    rdc("iptr", `BPOE_OFS_IPTR, 32'h00000600);
    rdc("count", `BPOE_OFS_COUNT, 32'h00000002);
    @(posedge ref_clk);
    int_req <= 1'b0;
    repeat (4) @(posedge ref_clk);
    go();
    chk("outputs", 32'h3, m.out_data.size());
    rdc("pointer", `BPOE_OFS_POINTER, 32'h00000FFD);
    $display("test interrupt done");
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_single();
    t_rep(1'b0, `BPOE_OP_INC_REP, 16'h0200);
    t_rep(1'b1, `BPOE_OP_DEC_REP, 16'h0300);
    t_wrap();
    t_illegal();
    t_intr();
    end_of_test();
  end
endmodule
